//--- src/sbs_pkg.sv
// Shared types and constants for the system bus slave interface
package sbs_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SIZE_W = 2;
  localparam int unsigned RESP_W = 3;

  // ------------------------------------------------------------
  // Response codes, ordered {wait, final, fault}
  // ------------------------------------------------------------
  localparam logic [RESP_W-1:0] RESP_DONE = 3'h0;
  localparam logic [RESP_W-1:0] RESP_ERROR = 3'h1;
  localparam logic [RESP_W-1:0] RESP_LAST = 3'h2;
  localparam logic [RESP_W-1:0] RESP_RETRACT = 3'h3;
  localparam logic [RESP_W-1:0] RESP_WAIT = 3'h4;
  localparam logic [RESP_W-1:0] RESP_RETRACT_NEXT = 3'h7;
  localparam int unsigned RESP_WAIT_BIT = 2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [SIZE_W-1:0] SIZE_RST = 2'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic {SBS_UNCHOSEN, SBS_CHOSEN} sbs_state_t;

  typedef struct packed {
    logic bus_clk;
    logic bus_reset_n;
    logic slave_select;
    logic write_direction;
    logic [SIZE_W-1:0] transfer_size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sbs_pins_t;

  localparam sbs_pins_t PINS_RST = '{1'b0, 1'b0, 1'b0, 1'b0, SIZE_RST, ADDR_RST, DATA_RST};

  typedef struct packed {
    logic ready;
    logic fault;
    logic final_beat;
    logic retract;
    logic [DATA_W-1:0] rdata;
  } sbs_user_resp_t;

endpackage : sbs_pkg

//--- src/sbs_slave.sv
// System bus slave: select-driven response and data phase control
// ------------------------------------------------------------
// Summary of operation
// (R1) Respond only according to decoder select
// (R2) Drive valid response in low phase
// (R3) Wait response for every extra cycle
// (R4) Done response on successful completion
// (R5) Last response when burst cannot continue
// (R6) Error response when transfer fails
// (R7) Retract lets long transfers free bus
// (R8) Simple mode holds error and last low
// (R9) Response lines released when not selected
// (R10) Response lines released during bus reset
// (R11) Falling-edge state machine gates data
// (R12) Bus reset forces unchosen state
// (R13) Write data captured on falling edge
// (R14) Write may be lengthened with wait
// (R15) Read data driven in final high phase
// (R16) Read data released during wait cycles
// (R17) Never drive data in first phase
// (R18) Data released in reset or unchosen
// (R19) Select and control sampled on falling edge
// (R20) Optional extra wait for write hold
// (R21) Response encoding on wait, last, error
// (R22) Retract takes two response cycles
// (R23) Responses undriven in high phase
// (R24) Shared 32-bit bidirectional data bus
// ------------------------------------------------------------
`timescale 1ns/1ps

module sbs_slave (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic bus_clk_i,
  input wire logic bus_reset_n_i,
  input wire logic slave_select_i,
  input wire logic write_direction_i,
  input wire logic [sbs_pkg::SIZE_W-1:0] transfer_size_i,
  input wire logic [sbs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sbs_pkg::DATA_W-1:0] shared_data_bus_i,
  output logic [sbs_pkg::DATA_W-1:0] shared_data_bus_o,
  output logic shared_data_bus_oe_o,
  output logic resp_wait_line_o,
  output logic resp_final_line_o,
  output logic resp_fault_line_o,
  output logic resp_oe_o,
  input wire logic simple_resp_i,
  input wire logic hold_wait_en_i,
  input wire sbs_pkg::sbs_user_resp_t usr_resp_i,
  output logic usr_access_o,
  output logic usr_write_o,
  output logic [sbs_pkg::SIZE_W-1:0] usr_size_o,
  output logic [sbs_pkg::ADDR_W-1:0] usr_addr_o,
  output logic usr_done_o,
  output logic [sbs_pkg::DATA_W-1:0] usr_wdata_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic resp_completes(input logic [sbs_pkg::RESP_W-1:0] code);
    resp_completes = ~code[sbs_pkg::RESP_WAIT_BIT];
  endfunction : resp_completes

  function automatic logic resp_succeeds(input logic [sbs_pkg::RESP_W-1:0] code);
    resp_succeeds = (code == sbs_pkg::RESP_DONE) || (code == sbs_pkg::RESP_LAST);
  endfunction : resp_succeeds

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  sbs_pkg::sbs_pins_t pins_raw;
  sbs_pkg::sbs_pins_t pins_meta;
  sbs_pkg::sbs_pins_t pins;
  logic bclk_prev;

  assign pins_raw = '{bus_clk_i, bus_reset_n_i, slave_select_i, write_direction_i,
                      transfer_size_i, addr_i, shared_data_bus_i};

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      pins_meta <= sbs_pkg::PINS_RST;
      pins <= sbs_pkg::PINS_RST;
      bclk_prev <= 1'b0;
    end
    else
    begin
      pins_meta <= pins_raw;
      pins <= pins_meta;
      bclk_prev <= pins.bus_clk;
    end
  end

  logic bclk_fall;
  logic bclk_rise;
  logic bus_in_reset;

  assign bclk_fall = bclk_prev & ~pins.bus_clk;
  assign bclk_rise = ~bclk_prev & pins.bus_clk;
  assign bus_in_reset = ~rst_b_i | ~pins.bus_reset_n;

  // ------------------------------------------------------------
  // Falling-edge state machine
  // ------------------------------------------------------------
  sbs_pkg::sbs_state_t state;
  logic [sbs_pkg::RESP_W-1:0] resp;
  logic xfer_write;
  logic hold_pending;
  logic new_xfer;

  assign new_xfer = (state == sbs_pkg::SBS_UNCHOSEN) || resp_completes(resp);

  always_ff @(posedge clk_sys_i)
  begin
    if (bus_in_reset)
      state <= sbs_pkg::SBS_UNCHOSEN; // [R12]
    else if (bclk_fall)
      state <= pins.slave_select ? sbs_pkg::SBS_CHOSEN : sbs_pkg::SBS_UNCHOSEN; // [R1] [R11] [R19]
  end

  // ------------------------------------------------------------
  // Response selection
  // ------------------------------------------------------------
  logic next_write;
  logic [sbs_pkg::RESP_W-1:0] next_resp;

  assign next_write = new_xfer ? pins.write_direction : xfer_write;

  always_comb
  begin
    if (resp == sbs_pkg::RESP_RETRACT_NEXT)
      next_resp = sbs_pkg::RESP_RETRACT; // [R22]
    else if (new_xfer && hold_wait_en_i && pins.write_direction)
      next_resp = sbs_pkg::RESP_WAIT; // [R20]
    else if (usr_resp_i.retract && !simple_resp_i)
      next_resp = sbs_pkg::RESP_RETRACT_NEXT; // [R7] [R22]
    else if (!usr_resp_i.ready)
      next_resp = sbs_pkg::RESP_WAIT; // [R3] [R14]
    else if (simple_resp_i)
      next_resp = sbs_pkg::RESP_DONE; // [R8]
    else if (usr_resp_i.fault)
      next_resp = sbs_pkg::RESP_ERROR; // [R6]
    else if (usr_resp_i.final_beat)
      next_resp = sbs_pkg::RESP_LAST; // [R5]
    else
      next_resp = sbs_pkg::RESP_DONE; // [R4]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (bus_in_reset)
    begin
      resp <= sbs_pkg::RESP_DONE;
      xfer_write <= 1'b0;
      hold_pending <= 1'b0;
    end
    else if (bclk_fall)
    begin
      if (pins.slave_select)
      begin
        resp <= hold_pending ? sbs_pkg::RESP_WAIT : next_resp; // [R21]
        xfer_write <= next_write;
        hold_pending <= 1'b0;
      end
      else
        resp <= sbs_pkg::RESP_DONE;
    end
  end

  // ------------------------------------------------------------
  // Response line drivers, low phase only
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (bus_in_reset)
    begin
      resp_oe_o <= 1'b0; // [R10]
      resp_wait_line_o <= 1'b0;
      resp_final_line_o <= 1'b0;
      resp_fault_line_o <= 1'b0;
    end
    else if (bclk_fall)
    begin
      resp_oe_o <= pins.slave_select; // [R2] [R9]
      {resp_wait_line_o, resp_final_line_o, resp_fault_line_o} <=
        hold_pending ? sbs_pkg::RESP_WAIT : next_resp; // [R21]
    end
    else if (bclk_rise)
      resp_oe_o <= 1'b0; // [R23]
  end

  // ------------------------------------------------------------
  // User side: access announcement and completion
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (bus_in_reset)
    begin
      usr_access_o <= 1'b0;
      usr_write_o <= 1'b0;
      usr_size_o <= sbs_pkg::SIZE_RST;
      usr_addr_o <= sbs_pkg::ADDR_RST;
    end
    else
    begin
      usr_access_o <= bclk_fall && pins.slave_select && new_xfer;
      if (bclk_fall && pins.slave_select && new_xfer)
      begin
        usr_write_o <= pins.write_direction; // [R19]
        usr_size_o <= pins.transfer_size;
        usr_addr_o <= pins.addr;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (bus_in_reset)
    begin
      usr_done_o <= 1'b0;
      usr_wdata_o <= sbs_pkg::DATA_RST;
    end
    else
    begin
      usr_done_o <= bclk_fall && (state == sbs_pkg::SBS_CHOSEN) && resp_succeeds(resp);
      if (bclk_fall && (state == sbs_pkg::SBS_CHOSEN) && resp_succeeds(resp) && xfer_write)
        usr_wdata_o <= pins.data; // [R13]
    end
  end

  // ------------------------------------------------------------
  // Read data driver, final high phase only
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (bus_in_reset)
    begin
      shared_data_bus_oe_o <= 1'b0; // [R18]
      shared_data_bus_o <= sbs_pkg::DATA_RST;
    end
    else if (bclk_fall)
      shared_data_bus_oe_o <= 1'b0; // [R17]
    else if (bclk_rise)
    begin
      if ((state == sbs_pkg::SBS_CHOSEN) && !xfer_write && resp_succeeds(resp))
      begin
        shared_data_bus_oe_o <= 1'b1; // [R15]
        shared_data_bus_o <= usr_resp_i.rdata;
      end
      else
        shared_data_bus_oe_o <= 1'b0; // [R16] [R18]
    end
  end

endmodule : sbs_slave

//--- sim/sbs_chk_sva.sv
// Concurrent checks on the bus slave ports
`timescale 1ns/1ps
module sbs_chk (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic bus_reset_n_i,
  input wire logic write_direction_i,
  input wire logic simple_resp_i,
  input wire logic resp_wait_line_o,
  input wire logic resp_final_line_o,
  input wire logic resp_fault_line_o,
  input wire logic resp_oe_o,
  input wire logic shared_data_bus_oe_o,
  input wire logic usr_access_o
);
  wire logic [2:0] code = {resp_wait_line_o, resp_final_line_o, resp_fault_line_o};
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  a_phase_no_overlap:
    assert property (!(resp_oe_o && shared_data_bus_oe_o)) else $error("resp and data overlap");
  a_no_reserved_code:
    assert property (resp_oe_o |-> code != 3'h5 && code != 3'h6) else $error("reserved code");
  a_simple_only:
    assert property (resp_oe_o && simple_resp_i |-> code[1:0] == 2'h0) else $error("simple code");
  a_retract_follow:
    assert property (resp_oe_o && code == 3'h7 |-> ##[1:16] resp_oe_o && code == 3'h3)
    else $error("retract not completed");
  a_read_drive_only:
    assert property (shared_data_bus_oe_o |-> !write_direction_i) else $error("data drive on write");
  a_access_resp:
    assert property (usr_access_o |-> ##[0:2] resp_oe_o) else $error("no response driven");
  a_reset_release:
    assert property (disable iff (1'b0) !rst_b_i |=> !resp_oe_o && !shared_data_bus_oe_o)
    else $error("drive during reset");
  a_bus_reset_idle:
    assert property (!bus_reset_n_i [*5] |-> !resp_oe_o && !shared_data_bus_oe_o && !usr_access_o)
    else $error("drive during bus reset");
endmodule : sbs_chk

bind sbs_slave sbs_chk u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .bus_reset_n_i(bus_reset_n_i), .write_direction_i(write_direction_i),
  .simple_resp_i(simple_resp_i), .resp_wait_line_o(resp_wait_line_o),
  .resp_final_line_o(resp_final_line_o), .resp_fault_line_o(resp_fault_line_o),
  .resp_oe_o(resp_oe_o), .shared_data_bus_oe_o(shared_data_bus_oe_o),
  .usr_access_o(usr_access_o));

//--- sim/sbs_master.sv
// Bus master and decoder model facing the slave
`timescale 1ns/1ps
module sbs_master (
  input wire logic [31:0] bus_i,
  input wire logic [2:0] resp_i,
  output logic bclk_o,
  output logic brst_n_o,
  output logic sel_o,
  output logic wr_o,
  output logic [31:0] addr_o,
  output logic [31:0] wd_o,
  output logic moe_o
);
  initial
  begin
    {bclk_o, sel_o, wr_o, moe_o, addr_o, wd_o} = '0;
    brst_n_o = 1'b1;
    #7;
    forever #120 bclk_o = ~bclk_o;
  end

  task automatic xfer(input logic w, input logic [31:0] a, d,
    output logic [2:0] r0, r1, output logic [31:0] q);
    int k;
    k = 0;
    r1 = 3'h4;
    @(posedge bclk_o);
    #1;
    sel_o = 1'b1;
    {wr_o, addr_o, wd_o} = {w, a, d};
    while (r1[2] && k < 40)
    begin
      @(posedge bclk_o);
      r1 = resp_i;
      if (k == 0)
        r0 = r1;
      k++;
      #1 moe_o = w;
    end
    sel_o = 1'b0;
    @(negedge bclk_o);
    q = bus_i;
    @(posedge bclk_o);
    #1 moe_o = 1'b0;
  endtask : xfer
endmodule : sbs_master

//--- sim/tb_top.sv
// Self-checking bench for the bus slave
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 0, rst_b_i = 0, simple = 0, hold = 0;
  logic bclk, brst_n, sel, wr, moe, doe, roe, rw, rf, re, wro;
  logic [31:0] addr, wd, dout, ua, uw, q;
  logic [1:0] usz;
  logic udone;
  int dones = 0;
  wire logic [31:0] bus = doe ? dout : moe ? wd : 32'hA5A5_A5A5 ^ {32{bclk}};
  sbs_pkg::sbs_user_resp_t ur = '0;
  int errors = 0, checks = 0, cyc = 0;

  sbs_slave DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_clk_i(bclk),
    .bus_reset_n_i(brst_n), .slave_select_i(sel), .write_direction_i(wr),
    .transfer_size_i(2'h2), .addr_i(addr), .shared_data_bus_i(bus), .shared_data_bus_o(dout),
    .shared_data_bus_oe_o(doe), .resp_wait_line_o(rw), .resp_final_line_o(rf),
    .resp_fault_line_o(re), .resp_oe_o(roe), .simple_resp_i(simple), .hold_wait_en_i(hold),
    .usr_resp_i(ur), .usr_access_o(), .usr_write_o(wro), .usr_size_o(usz), .usr_addr_o(ua),
    .usr_done_o(udone), .usr_wdata_o(uw));
  sbs_master bfm (.bus_i(bus), .resp_i({rw, rf, re}), .bclk_o(bclk), .brst_n_o(brst_n),
    .sel_o(sel), .wr_o(wr), .addr_o(addr), .wd_o(wd), .moe_o(moe));

  initial
  begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // Completion pulses seen on the user side
  always @(posedge clk_sys_i)
  begin
    if (udone === 1'b1)
      dones++;
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic setr(input sbs_pkg::sbs_user_resp_t v);
    @(posedge clk_sys_i);
    #1 ur = v;
  endtask : setr

  task automatic go(input logic w, input logic [31:0] a, d, input logic [2:0] f, l);
    logic [2:0] r0, r1;
    bfm.xfer(w, a, d, r0, r1, q);
    chk("first resp", 32'(f), 32'(r0));
    chk("last resp", 32'(l), 32'(r1));
  endtask : go

  task automatic t_write;
    setr('{1'b1, 1'b0, 1'b0, 1'b0, 32'h0});
    go(1'b1, 32'h0000_1004, 32'hCAFE_0001, 3'h0, 3'h0);
    chk("wdata", 32'hCAFE_0001, uw);
    chk("addr", 32'h0000_1004, ua);
    chk("write", 32'h1, 32'(wro));
    chk("size", 32'h2, 32'(usz));
    chk("done count", 32'h1, 32'(dones));
    setr('{1'b1, 1'b0, 1'b0, 1'b0, 32'h1234_5678});
    go(1'b0, 32'h0000_2000, 32'h0, 3'h0, 3'h0);
    chk("rdata", 32'h1234_5678, q);
    chk("done count", 32'h2, 32'(dones));
    $display("test write read done");
  endtask : t_write

  task automatic t_codes;
    logic [2:0] f [3] = '{3'h1, 3'h2, 3'h7};
    logic [2:0] l [3] = '{3'h1, 3'h2, 3'h3};
    for (int i = 0; i < 3; i++)
    begin
      setr('{1'b1, i == 0, i == 1, i == 2, 32'h0});
      go(1'b0, 32'h0000_3000, 32'h0, f[i], l[i]);
    end
    setr('{1'b1, 1'b0, 1'b0, 1'b0, 32'h0});
    go(1'b0, 32'h0000_3000, 32'h0, 3'h0, 3'h0);
    $display("test codes done");
  endtask : t_codes

  task automatic t_wait;
    setr('{1'b0, 1'b0, 1'b0, 1'b0, 32'h0});
    fork
      begin
        repeat (60) @(posedge clk_sys_i);
        #1 ur.ready = 1'b1;
      end
    join_none
    go(1'b1, 32'h0000_4000, 32'h5555_AAAA, 3'h4, 3'h0);
    chk("wdata", 32'h5555_AAAA, uw);
    setr('{1'b1, 1'b1, 1'b1, 1'b0, 32'h0});
    simple = 1'b1;
    go(1'b1, 32'h0000_5000, 32'h0000_0005, 3'h0, 3'h0);
    simple = 1'b0;
    setr('{1'b1, 1'b0, 1'b0, 1'b0, 32'h0});
    hold = 1'b1;
    go(1'b1, 32'h0000_6000, 32'h0000_0006, 3'h4, 3'h0);
    hold = 1'b0;
    $display("test wait done");
  endtask : t_wait

  task automatic t_reset;
    chk("resp oe idle", 32'h0, 32'(roe));
    @(posedge clk_sys_i);
    #1 {bfm.brst_n_o, bfm.sel_o} = 2'b01;
    repeat (20) @(posedge clk_sys_i);
    chk("resp oe reset", 32'h0, 32'(roe));
    chk("data oe reset", 32'h0, 32'(doe));
    #1 {bfm.brst_n_o, bfm.sel_o} = 2'b10;
    repeat (20) @(posedge clk_sys_i);
    go(1'b1, 32'h0000_7000, 32'h0000_0007, 3'h0, 3'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    t_write();
    t_codes();
    t_wait();
    t_reset();
    summarize();
  end

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end
endmodule : tb_top
